// ---- rtl/mii_mgmt_pkg.sv ----
// Shared constants and types of the management access engine
package mii_mgmt_pkg;

  // Register byte offsets
  localparam logic [7:0] SETUP_OFS   = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] WDATA_OFS   = 8'h08;
  localparam logic [7:0] RDATA_OFS   = 8'h0c;
  localparam logic [7:0] INTSTAT_OFS = 8'h10;
  localparam logic [7:0] INTMASK_OFS = 8'h14;

  // Setup register fields
  localparam int DIV_LSB    = 0;
  localparam int DIV_W      = 6;
  localparam int ENABLE_BIT = 6;

  // Control register fields
  localparam int PHY_ADDRESS_FIELD_LSB    = 24;
  localparam int REGNUM_LSB   = 16;
  localparam int OPCODE_LSB   = 14;
  localparam int INITIATE_BIT = 11;
  localparam int READY_BIT    = 7;

  // Interrupt bits
  localparam int DONE_IRQ_BIT = 0;

  // Operation codes and frame pieces
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] TA_WRITE   = 2'h2;
  localparam int FRAME_BITS    = 64;
  localparam int PREAMBLE_BITS = 32;
  localparam int TA_FIRST_BIT  = 46;
  localparam int DATA_FIRST_BIT = 48;

  // Reset values
  localparam logic [DIV_W-1:0] DIV_RESET = 6'h00;
  localparam logic [4:0] INTERNAL_PHY_ADDR_RESET = 5'h01;

  // Timing: link clock ceiling and the least half period in clk cycles
  localparam longint CLK_HZ     = 40000000;
  localparam longint MDC_MAX_HZ = 2500000;
  localparam int MIN_HALF_CYCLES =
    int'((CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ));

  typedef struct packed {
    logic [4:0] phyAddr;
    logic [4:0] regNum;
    logic [1:0] opCode;
    logic       initiate;
  } ctrl_t;

  typedef struct packed {
    logic             enable;
    logic [DIV_W-1:0] divide;
  } setup_t;

  typedef enum logic [4:0] {
    S_IDLE    = 5'b00001,
    S_FRAME   = 5'b00010,
    S_INTACC  = 5'b00100,
    S_INTWAIT = 5'b01000,
    S_DONE    = 5'b10000
  } mgmt_state_t;

endpackage : mii_mgmt_pkg

// ---- rtl/mgmt_reg_mem.sv ----
// Register store of the internal PCS/PMA sublayer, registered read data
`timescale 1ns/1ps
module mgmt_reg_mem #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // Access port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0;
    end else begin
      rdata <= we ? wdata : mem[addr];
    end
  end

endmodule : mgmt_reg_mem

// ---- rtl/mii_management_access.sv ----
// Clause 22 management access engine with APB registers
//
// Functional notes
// - PHY and register chosen by control fields
// - Management clock never faster than 2.5 MHz
// - One shared data line plus driven clock
// - Initiate bit write launches the transfer
// - Operation code 01 means write
// - Operation code 10 means read
// - Read result lands in read-data register
// - Ready bit 7 set when transfer completes
// - Completion also raises an interrupt
// - Other registers stay accessible during transfers
// - Rewrite while busy is stored and deferred
// - Internal PHY address reaches internal registers
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module mii_management_access
  import mii_mgmt_pkg::*;
#(
  parameter logic [4:0] INTERNAL_PHY_ADDR = mii_mgmt_pkg::INTERNAL_PHY_ADDR_RESET
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Management link
  output logic             mdc,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioOe,
  // Interrupt
  output logic             irq
);
  import mii_mgmt_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Registers and state

  setup_t      setup;
  ctrl_t       ctrl;
  logic [15:0] wrData;
  logic [15:0] rdData;
  logic        intStat;
  logic        intMask;
  logic        pending;
  mgmt_state_t state;
  ctrl_t       act;
  logic [FRAME_BITS-1:0] txShift;
  logic [15:0] rxShift;
  logic [5:0]  bitIdx;
  logic [7:0]  halfCnt;
  logic        mdioMeta;
  logic        mdioSync;
  logic [15:0] memRdata;

  //////////////////////////////////////////////////////////////////////////
  // APB decode

  wire         access    = psel & penable & pready;
  wire         wrAccess  = access & pwrite;
  wire         selSetup  = (paddr == SETUP_OFS);
  wire         selCtrl   = (paddr == CONTROL_OFS);
  wire         selWdata  = (paddr == WDATA_OFS);
  wire         selRdata  = (paddr == RDATA_OFS);
  wire         selStat   = (paddr == INTSTAT_OFS);
  wire         selMask   = (paddr == INTMASK_OFS);
  wire         mapped    = selSetup | selCtrl | selWdata | selRdata |
                           selStat | selMask;
  wire         ready     = (state == S_IDLE) & ~pending;
  wire         wrCtrl    = wrAccess & selCtrl;

  wire [31:0] setupWord = {25'h0, setup.enable, setup.divide};
  wire [31:0] ctrlWord  = {3'h0, ctrl.phyAddr, 3'h0, ctrl.regNum,
                           ctrl.opCode, 2'h0, ctrl.initiate, 3'h0,
                           ready, 7'h0};
  wire [31:0] rdMux =
    selSetup ? setupWord :
    selCtrl  ? ctrlWord :
    selWdata ? {16'h0, wrData} :
    selRdata ? {16'h0, rdData} :
    selStat  ? {31'h0, intStat} :
    selMask  ? {31'h0, intMask} : 32'h0;

  // One wait state on every access, in any sequencer state, so the
  // register bus never stalls behind a slow management frame.
  // Unmapped offsets answer with an error, read zero and store nothing.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rdMux : 32'h0;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Software registers

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      setup  <= '{enable: 1'b0, divide: DIV_RESET};
      wrData <= 16'h0;
      intMask <= 1'b0;
    end else if (wrAccess) begin
      if (selSetup) begin
        setup.divide <= pwdata[DIV_LSB +: DIV_W];
        setup.enable <= pwdata[ENABLE_BIT];
      end
      if (selWdata) begin
        wrData <= pwdata[15:0];
      end
      if (selMask) begin
        intMask <= pwdata[DONE_IRQ_BIT];
      end
    end
  end

  // Control is always stored; a write while busy waits its turn
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= '0;
    end else if (wrCtrl) begin
      ctrl.phyAddr  <= pwdata[PHY_ADDRESS_FIELD_LSB +: 5];
      ctrl.regNum   <= pwdata[REGNUM_LSB +: 5];
      ctrl.opCode   <= pwdata[OPCODE_LSB +: 2];
      ctrl.initiate <= pwdata[INITIATE_BIT];
    end
  end

  wire startNow = (state == S_IDLE) & pending & setup.enable;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending <= 1'b0;
    end else if (wrCtrl & pwdata[INITIATE_BIT]) begin
      pending <= 1'b1;
    end else if (startNow) begin
      pending <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Completion interrupt, set wins over write-one-to-clear

  wire doneEvt = (state == S_DONE);
  wire clrStat = wrAccess & selStat & pwdata[DONE_IRQ_BIT];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      intStat <= 1'b0;
      irq     <= 1'b0;
    end else begin
      intStat <= doneEvt | (intStat & ~clrStat);
      irq     <= (doneEvt | (intStat & ~clrStat)) & intMask;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Link clock divider and data line synchroniser

  wire [7:0] divHalf = {2'h0, setup.divide} + 8'h01;
  wire [7:0] halfLen = (divHalf < 8'(MIN_HALF_CYCLES)) ?
                       8'(MIN_HALF_CYCLES) : divHalf;
  wire       tick    = (state == S_FRAME) & (halfCnt == halfLen - 8'h01);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halfCnt  <= 8'h0;
      mdioMeta <= 1'b0;
      mdioSync <= 1'b0;
    end else begin
      halfCnt  <= (state != S_FRAME || tick) ? 8'h0 : halfCnt + 8'h01;
      mdioMeta <= mdioIn;
      mdioSync <= mdioMeta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transfer sequencer
  // The frame word is built from the live control and write-data
  // registers at launch; later rewrites only touch the queued copy.
  // Internal addresses bypass the pins and use the local store.

  wire        toInternal = (ctrl.phyAddr == INTERNAL_PHY_ADDR);
  wire        actRead    = (act.opCode == OP_READ);
  wire        actWrite   = (act.opCode == OP_WRITE);
  wire [5:0]  nextIdx    = bitIdx + 6'h01;
  wire        lastBit    = (bitIdx == 6'(FRAME_BITS - 1));
  wire        sampleBit  = actRead & (bitIdx >= 6'(DATA_FIRST_BIT));
  wire        driveNext  = ~(actRead & (nextIdx >= 6'(TA_FIRST_BIT)));
  wire [FRAME_BITS-1:0] frame = {{PREAMBLE_BITS{1'b1}}, START_CODE,
                                 ctrl.opCode, ctrl.phyAddr, ctrl.regNum,
                                 TA_WRITE, wrData};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= S_IDLE;
      act     <= '0;
      txShift <= '0;
      rxShift <= 16'h0;
      bitIdx  <= 6'h0;
      mdc     <= 1'b0;
      mdioOut <= 1'b1;
      mdioOe  <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (startNow) begin
            act    <= ctrl;
            bitIdx <= 6'h0;
            if (toInternal) begin
              state <= S_INTACC;
            end else begin
              state   <= S_FRAME;
              txShift <= frame;
              mdioOut <= frame[FRAME_BITS-1];
              mdioOe  <= 1'b1;
            end
          end
        end
        S_FRAME: begin
          if (tick && !mdc) begin
            mdc <= 1'b1;
            if (sampleBit) begin
              rxShift <= {rxShift[14:0], mdioSync};
            end
          end else if (tick) begin
            mdc <= 1'b0;
            if (lastBit) begin
              mdioOe  <= 1'b0;
              mdioOut <= 1'b1;
              state   <= S_DONE;
            end else begin
              bitIdx  <= nextIdx;
              txShift <= {txShift[FRAME_BITS-2:0], 1'b1};
              mdioOut <= txShift[FRAME_BITS-2];
              mdioOe  <= driveNext;
            end
          end
        end
        S_INTACC: begin
          state <= S_INTWAIT;
        end
        S_INTWAIT: begin
          rxShift <= memRdata;
          state   <= S_DONE;
        end
        S_DONE: begin
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Read result is published only for read operations
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= 16'h0;
    end else if (doneEvt && actRead) begin
      rdData <= rxShift;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Internal sublayer registers

  mgmt_reg_mem #(
    .AW (5),
    .DW (16)
  ) u_int_regs (
    .clk   (clk),
    .rst_b (rst_b),
    .we    ((state == S_INTACC) & actWrite),
    .addr  (act.regNum),
    .wdata (wrData),
    .rdata (memRdata)
  );

endmodule : mii_management_access

// ---- testbench/mii_mgmt_props.sv ----
// Port checker of the management access engine
`timescale 1ns/1ps
module mii_mgmt_props
  import mii_mgmt_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Link and interrupt
  input wire logic        mdc,
  input wire logic        mdioOut,
  input wire logic        mdioOe,
  input wire logic        irq
);
  logic [6:0] rises;
  logic       mdcQ;
  logic       oeQ;
  logic       wrDone;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  assign wrDone = pready && pwrite;
  // Link clock rises counted from the start of each driven frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rises <= 7'h00;
      mdcQ <= 1'b0;
      oeQ <= 1'b0;
    end else begin
      mdcQ <= mdc;
      oeQ <= mdioOe;
      if (mdioOe && !oeQ)
        rises <= 7'h00;
      else if (mdc && !mdcQ)
        rises <= rises + 7'h01;
    end
  end
  ////////////////////////////////////////
  sequence s_answer;
    !pready ##1 pready ##1 !pready;
  endsequence
  sequence s_high;
    mdc [*8];
  endsequence
  sequence s_low;
    !mdc [*8];
  endsequence
  AST_MDC_HIGH: assert property ($rose(mdc) |-> s_high)
    else $error("link clock high phase too short");
  AST_MDC_LOW: assert property ($fell(mdc) |-> s_low)
    else $error("link clock low phase too short");
  AST_DATA_STEADY: assert property (mdc |-> $stable(mdioOut) && $stable(mdioOe))
    else $error("data line moved while link clock high");
  AST_OE_START: assert property ($rose(mdioOe) |-> !mdc && mdioOut)
    else $error("frame does not start low with a one");
  AST_FRAME_LEN: assert property ($fell(mdioOe) |-> rises == 7'h2e || rises == 7'h40)
    else $error("driven part of frame has wrong length");
  AST_APB_WAIT: assert property ($rose(penable) && psel |-> s_answer)
    else $error("bus access not answered after one wait");
  AST_READY_BUSY: assert property (pready && !pwrite && paddr == CONTROL_OFS && mdioOe |-> !prdata[READY_BIT])
    else $error("ready shown while frame driven");
  AST_IRQ_CLEAR: assert property ($fell(irq) |-> $past(wrDone) || $past(wrDone, 2))
    else $error("interrupt dropped without a write");
endmodule : mii_mgmt_props

// ---- testbench/phy_mgmt_model.sv ----
// Behavioural far-end management port with a small register file
`timescale 1ns/1ps
module phy_mgmt_model #(
  parameter logic [4:0] ADDR = 5'h03
) (
  // Link
  input  wire logic mdc,
  input  wire logic line,
  output logic      oe,
  output logic      drv
);
  logic [15:0] mem [32];
  logic [63:0] sh;
  logic [63:0] lastFrame;
  logic [11:0] hdr = 12'h000;
  int          r = 0;
  int          frames = 0;
  logic        rdHit;
  initial oe = 1'b0;
  initial drv = 1'b1;
  assign rdHit = hdr[11:10] == 2'h2 && hdr[9:5] == ADDR;
  ////////////////////////////////////////
  always @(posedge mdc) begin
    sh = {sh[62:0], line};
    r = r + 1;
    if (r == 46)
      hdr = sh[11:0];
    if (r == 64) begin
      if (hdr[11:10] == 2'h1 && hdr[9:5] == ADDR)
        mem[hdr[4:0]] = sh[15:0];
      lastFrame = sh;
      frames = frames + 1;
      r = 0;
    end
  end
  // Answer reads: zero in second turnaround bit, then data
  always @(negedge mdc) begin
    if (rdHit && r == 47) begin
      oe = 1'b1;
      drv = 1'b0;
    end else if (rdHit && r > 47) begin
      drv = mem[hdr[4:0]][63-r];
    end else begin
      oe = 1'b0;
    end
  end
endmodule : phy_mgmt_model

// ---- testbench/mii_management_access_tb.sv ----
// Testbench of the management access engine
`timescale 1ns/1ps
module mii_management_access_tb;
  import mii_mgmt_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, mdc, mdioOut, mdioOe, irq, phyOe, phyDrv, se;
  wire         mdio = mdioOe ? mdioOut : (phyOe ? phyDrv : 1'b1);
  int          errors = 0;
  int          checks = 0;
  always #12.5 clk = ~clk;
  mii_management_access dut_u (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mdc(mdc),
    .mdioIn(mdio), .mdioOut(mdioOut), .mdioOe(mdioOe), .irq(irq));
  phy_mgmt_model phy_u (.mdc(mdc), .line(mdio), .oe(phyOe), .drv(phyDrv));
  ////////////////////////////////////////
  task automatic cmp(input string what, input logic [63:0] exp, got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      apb(1'b0, CONTROL_OFS, 32'h0);
      n++;
    end while (rd[READY_BIT] !== 1'b1 && n < 400);
    if (n >= 400) errors++;
    repeat (2) @(posedge clk);
  endtask : wait_ready
  function automatic logic [31:0] ctl(logic [1:0] op, logic [4:0] ph, rg);
    return {3'h0, ph, 3'h0, rg, op, 2'h0, 1'b1, 11'h0};
  endfunction : ctl
  // One transfer, then clear its status; frame checked on the wire
  task automatic xfer(logic [1:0] op, logic [4:0] ph, rg, logic [15:0] d);
    apb(1'b1, CONTROL_OFS, ctl(op, ph, rg));
    apb(1'b0, INTMASK_OFS, 32'h0);
    cmp("mask mid transfer", 32'h1, rd);
    wait_ready();
    cmp("control", ctl(op, ph, rg) | 32'h80, rd);
    cmp("irq", 1'b1, irq);
    cmp("frame", {32'hffffffff, START_CODE, op, ph, rg, TA_WRITE, d},
        phy_u.lastFrame);
    apb(1'b1, INTSTAT_OFS, 32'h1);
    apb(1'b0, INTSTAT_OFS, 32'h0);
    cmp("status", 32'h0, rd);
    cmp("irq cleared", 1'b0, irq);
  endtask : xfer
  task automatic t_reset();
    for (int a = 0; a < 7; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      cmp("reset value", (a == 1) ? 32'h80 : 32'h0, rd);
      cmp("slave error", a == 6, se);
    end
    $display("reset test done");
  endtask : t_reset
  task automatic t_write_read();
    apb(1'b1, SETUP_OFS, 32'h1 << ENABLE_BIT);
    apb(1'b1, INTMASK_OFS, 32'h1);
    apb(1'b1, WDATA_OFS, 32'habcd);
    xfer(OP_WRITE, 5'h03, 5'h02, 16'habcd);
    xfer(OP_READ, 5'h03, 5'h02, 16'habcd);
    apb(1'b0, RDATA_OFS, 32'h0);
    cmp("read data", 32'habcd, rd);
    $display("write and read test done");
  endtask : t_write_read
  task automatic t_queued();
    int n;
    int base;
    base = phy_u.frames;
    apb(1'b1, WDATA_OFS, 32'h1234);
    apb(1'b1, CONTROL_OFS, ctl(OP_WRITE, 5'h03, 5'h05));
    apb(1'b1, CONTROL_OFS, ctl(OP_READ, 5'h03, 5'h05));
    n = 0;
    while (phy_u.frames != base + 2 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) errors++;
    wait_ready();
    cmp("queued control", ctl(OP_READ, 5'h03, 5'h05) | 32'h80, rd);
    apb(1'b0, RDATA_OFS, 32'h0);
    cmp("queued read", 32'h1234, rd);
    apb(1'b1, INTSTAT_OFS, 32'h1);
    $display("queued test done");
  endtask : t_queued
  task automatic t_internal();
    int base;
    base = phy_u.frames;
    apb(1'b1, INTMASK_OFS, 32'h0);
    apb(1'b1, WDATA_OFS, 32'h5a5a);
    apb(1'b1, CONTROL_OFS, ctl(OP_WRITE, INTERNAL_PHY_ADDR_RESET, 5'h03));
    wait_ready();
    apb(1'b1, CONTROL_OFS, ctl(OP_READ, INTERNAL_PHY_ADDR_RESET, 5'h03));
    wait_ready();
    apb(1'b0, RDATA_OFS, 32'h0);
    cmp("internal read", 32'h5a5a, rd);
    cmp("no frame", base, phy_u.frames);
    cmp("masked irq", 1'b0, irq);
    apb(1'b0, INTSTAT_OFS, 32'h0);
    cmp("masked status", 32'h1, rd);
    $display("internal test done");
  endtask : t_internal
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_write_read();
    t_queued();
    t_internal();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule : mii_management_access_tb
bind mii_management_access mii_mgmt_props chk_u (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .mdc(mdc), .mdioOut(mdioOut),
  .mdioOe(mdioOe), .irq(irq));
